// ### src/rmp_pkg.sv
package rmp_pkg;
    // ------------------------------------------------------------
    // Clock and line timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int BIT_NS = 100;
    localparam int BIT_CYC = BIT_NS * CLK_MHZ / 1000;
    localparam int MID_GAP_MIN = BIT_CYC - 1;
    localparam int MID_GAP_MAX = BIT_CYC + 2;
    localparam int DIBIT_CYC_10 = 2 * BIT_CYC;
    localparam int DIBIT_CYC_100 = 1;
    localparam int POL_IDLE_CYC = 16;
    localparam int JABBER_MS = 45;
    localparam int JABBER_CYC = JABBER_MS * CLK_MHZ * 1000;
    localparam int LINK_LOSS_MS = 150;
    localparam int LINK_LOSS_CYC = LINK_LOSS_MS * CLK_MHZ * 1000;
    localparam int STRAP_SETTLE_CYC = 4;
    localparam int RX_FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // Transceiver status words
    // ------------------------------------------------------------
    localparam int REG_BASIC_STATUS = 1;
    localparam int JABBER_BIT = 1;
    localparam int REG_SPECIAL_CS = 27;
    localparam int POL_BIT = 4;
    localparam int LINK_BIT = 2;

    // ------------------------------------------------------------
    // Controller registers on AHB-Lite
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TXDATA = 8'h04;
    localparam logic [7:0] OFS_RXDATA = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam int CTRL_SPEED100_BIT = 0;
    localparam int RXDATA_VALID_BIT = 8;
    localparam int STAT_TXBUSY_BIT = 0;
    localparam int STAT_CRS_BIT = 1;
    localparam int STAT_OVERRUN_BIT = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        RMP_TX_IDLE = 2'b01,
        RMP_TX_SEND = 2'b10
    } rmp_tx_state_e;
endpackage : rmp_pkg

// ### src/rmp_rmii_if.sv
`timescale 1ns/10ps
interface rmp_rmii_if (
    input wire logic ref_clk  // Continuous shared reference clock
);
    logic [1:0] txd;
    logic tx_en;
    logic [1:0] rxd;
    logic rx_er;
    logic crs_dv;

    modport phy (input ref_clk, input txd, input tx_en, output rxd, output rx_er, output crs_dv);
    modport mac (input ref_clk, output txd, output tx_en, input rxd, input rx_er, input crs_dv);
endinterface : rmp_rmii_if

// ### src/rmp_phy.sv
// Local design decisions: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
// Function
// - Deliver 4-bit nibbles at 2.5 MHz
// - Detect, correct, flag reversed receive polarity
// - Decode Manchester into bits, then nibbles
// - Link pulses in idle keep link up
// - MII nibble valid at 2.5 MHz edge
// - RMII di-bits valid at reference clock edge
// - Abort transmit on jabber within 45 ms
// - Clear jabber when transmit enable drops
// - Jabber flag in status register 1 bit 1
// - Shared clock, 2-bit paths, both speeds
// - Six link signals
// - Carrier sense asserts on carrier at once
// - Carrier sense drops on nibble boundaries
// - Toggle carrier sense while buffer drains
// - False carrier keeps carrier sense asserted
// - Receive data 00 until decoded data
// - Sample clock mode strap at start-up
// - System supplies 50 MHz reference clock
// - Output mode drives clock, disables interrupt
// - Reference clock times all, no transmit buffering
// - Elasticity buffer on receive path
// - Transmit data 00 while enable low
// - Valid transmit di-bit every period
module rmp_phy #(
    parameter int FIFO_DEPTH = rmp_pkg::RX_FIFO_DEPTH,
    parameter int JABBER_CYCLES = rmp_pkg::JABBER_CYC,
    parameter int LINK_LOSS_CYCLES = rmp_pkg::LINK_LOSS_CYC
) (
    input wire logic mclk,                     // 50 MHz reference clock
    input wire logic sys_rst,                  // Synchronous reset, active high
    rmp_rmii_if.phy link,                      // RMII toward the controller
    input wire logic line_rx_in,               // Sliced receive pair level
    input wire logic squelch_in,               // Squelch passed on receive pair
    input wire logic speed_100,                // 1 selects 100 Mb/s timing
    input wire logic clock_mode_strap,         // Strap: 1 selects clock output mode
    output logic line_tx_en,                   // Transmit enable toward the line
    output logic [1:0] line_txd,               // Transmit di-bit toward the line
    output logic [15:0] status_basic,          // Status word 1
    output logic [15:0] status_special,        // Status word 27
    output logic ref_clock_output_oe,          // Reference clock pin driven
    output logic interrupt_output_n,           // Interrupt, active low
    output logic interrupt_output_n_oe         // Interrupt pin driven
);
    import rmp_pkg::*;

    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int JW = $clog2(JABBER_CYCLES + 1);
    localparam int LW = $clog2(LINK_LOSS_CYCLES + 1);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic line_q;
    logic carrier;
    logic strap_q;

    always_ff @(posedge mclk) begin
        sync1 <= {clock_mode_strap, squelch_in, line_rx_in};
        sync2 <= sync1;
        sync3 <= sync2;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line_q <= 1'b0;
            carrier <= 1'b0;
            strap_q <= 1'b0;
        end else begin
            if (sync2[0] == sync3[0]) line_q <= sync3[0];
            if (sync2[1] == sync3[1]) carrier <= sync3[1];
            if (sync2[2] == sync3[2]) strap_q <= sync3[2];
        end
    end

    // ------------------------------------------------------------
    // Clock mode strap
    // ------------------------------------------------------------
    logic [2:0] settle_cnt;
    logic strap_done;
    logic clk_out_mode;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            settle_cnt <= 3'h0;
            strap_done <= 1'b0;
            clk_out_mode <= 1'b0;
        end else if (!strap_done) begin
            settle_cnt <= settle_cnt + 3'h1;
            if (settle_cnt == 3'(STRAP_SETTLE_CYC - 1)) begin
                strap_done <= 1'b1;
                clk_out_mode <= strap_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Polarity, link pulses and Manchester decoding
    // ------------------------------------------------------------
    logic polarity_reversed_flag;
    logic [4:0] idle_cnt;
    logic idle_last;
    logic line_c;
    logic line_prev;
    logic [3:0] gap;
    logic link_up;
    logic [LW-1:0] link_timer;
    logic bit_stb;
    logic bit_val;
    logic rx_err_q;

    assign line_c = line_q ^ polarity_reversed_flag;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            polarity_reversed_flag <= 1'b0;
            idle_cnt <= 5'h00;
            idle_last <= 1'b0;
        end else if (carrier) begin
            idle_cnt <= 5'h00;
        end else begin
            idle_last <= line_q;
            if (line_q != idle_last) begin
                idle_cnt <= 5'h00;
            end else if (idle_cnt == 5'(POL_IDLE_CYC)) begin
                polarity_reversed_flag <= line_q;
            end else begin
                idle_cnt <= idle_cnt + 5'h01;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link_up <= 1'b0;
            link_timer <= '0;
        end else if (!carrier && line_c && !line_prev) begin
            link_up <= 1'b1;
            link_timer <= LW'(LINK_LOSS_CYCLES);
        end else if (carrier) begin
            link_timer <= LW'(LINK_LOSS_CYCLES);
        end else if (link_timer != '0) begin
            link_timer <= link_timer - LW'(1);
        end else begin
            link_up <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line_prev <= 1'b0;
            gap <= 4'h0;
            bit_stb <= 1'b0;
            bit_val <= 1'b0;
            rx_err_q <= 1'b0;
        end else begin
            line_prev <= line_c;
            bit_stb <= 1'b0;
            rx_err_q <= 1'b0;
            // Only a mid-bit edge restarts the gap; bit-boundary edges are skipped
            if (line_c != line_prev && gap >= 4'(MID_GAP_MIN)) begin
                gap <= 4'h0;
                if (carrier) begin
                    bit_stb <= 1'b1;
                    bit_val <= line_c;
                end
            end else if (gap != 4'hF) begin
                gap <= gap + 4'h1;
            end
            if (carrier && gap == 4'(MID_GAP_MAX)) rx_err_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Nibble assembly and elasticity buffer
    // ------------------------------------------------------------
    logic [3:0] shreg;
    logic [1:0] bit_cnt;
    logic [3:0] fifo_mem [FIFO_DEPTH];
    logic [PW:0] wr_ptr;
    logic [PW:0] rd_ptr;
    logic fifo_empty;
    logic fifo_full;
    logic push;
    logic pop;

    assign fifo_empty = (wr_ptr == rd_ptr);
    assign fifo_full = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
    assign push = bit_stb && (bit_cnt == 2'h3) && !fifo_full;

    always_ff @(posedge mclk) begin
        if (sys_rst || !carrier) begin
            bit_cnt <= 2'h0;
            shreg <= 4'h0;
        end else if (bit_stb) begin
            shreg <= {bit_val, shreg[3:1]};
            bit_cnt <= bit_cnt + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) fifo_mem[wr_ptr[PW-1:0]] <= {bit_val, shreg[3:1]};
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + (PW+1)'(1);
            if (pop) rd_ptr <= rd_ptr + (PW+1)'(1);
        end
    end

    // ------------------------------------------------------------
    // Receive di-bit output
    // ------------------------------------------------------------
    logic [3:0] dibit_cnt;
    logic dibit_tick;
    logic phase;
    logic active;
    logic [3:0] cur_nib;
    logic [3:0] dibit_last;

    assign dibit_last = speed_100 ? 4'(DIBIT_CYC_100 - 1) : 4'(DIBIT_CYC_10 - 1);
    assign dibit_tick = (dibit_cnt == dibit_last);
    assign pop = dibit_tick && phase && !fifo_empty;

    always_ff @(posedge mclk) begin
        if (sys_rst || dibit_tick) begin
            dibit_cnt <= 4'h0;
        end else begin
            dibit_cnt <= dibit_cnt + 4'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            phase <= 1'b0;
            active <= 1'b0;
            cur_nib <= 4'h0;
            link.rxd <= 2'b00;
        end else if (dibit_tick) begin
            phase <= ~phase;
            if (phase) begin
                active <= !fifo_empty;
                cur_nib <= fifo_mem[rd_ptr[PW-1:0]];
                link.rxd <= fifo_empty ? 2'b00 : fifo_mem[rd_ptr[PW-1:0]][1:0];
            end else begin
                link.rxd <= active ? cur_nib[3:2] : 2'b00;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link.crs_dv <= 1'b0;
        end else if (carrier) begin
            link.crs_dv <= 1'b1;
        end else if (dibit_tick) begin
            link.crs_dv <= !phase && (active || link.crs_dv);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            link.rx_er <= 1'b0;
        end else begin
            link.rx_er <= rx_err_q;
        end
    end

    // ------------------------------------------------------------
    // Transmit path and jabber
    // ------------------------------------------------------------
    logic jabber;
    logic [JW-1:0] jab_cnt;

    always_ff @(posedge mclk) begin
        if (sys_rst || !link.tx_en) begin
            jab_cnt <= '0;
            jabber <= 1'b0;
        end else if (jab_cnt == JW'(JABBER_CYCLES)) begin
            jabber <= 1'b1;
        end else begin
            jab_cnt <= jab_cnt + JW'(1);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            line_tx_en <= 1'b0;
            line_txd <= 2'b00;
        end else begin
            line_tx_en <= link.tx_en && !jabber;
            line_txd <= (link.tx_en && !jabber) ? link.txd : 2'b00;
        end
    end

    // ------------------------------------------------------------
    // Status words and shared pins
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            status_basic <= 16'h0000;
            status_special <= 16'h0000;
            ref_clock_output_oe <= 1'b0;
            interrupt_output_n <= 1'b1;
            interrupt_output_n_oe <= 1'b0;
        end else begin
            status_basic <= 16'h0000;
            status_basic[JABBER_BIT] <= jabber;
            status_basic[LINK_BIT] <= link_up;
            status_special <= 16'h0000;
            status_special[POL_BIT] <= polarity_reversed_flag;
            ref_clock_output_oe <= strap_done && clk_out_mode;
            interrupt_output_n <= clk_out_mode || !jabber;
            interrupt_output_n_oe <= strap_done && !clk_out_mode;
        end
    end
endmodule : rmp_phy

// ### src/rmp_mac.sv
`timescale 1ns/10ps
module rmp_mac (
    input wire logic mclk,               // 50 MHz reference clock
    input wire logic sys_rst,            // Synchronous reset, active high
    rmp_rmii_if.mac link,                // RMII toward the transceiver
    input wire logic hsel,               // AHB slave select
    input wire logic [31:0] haddr,       // AHB address
    input wire logic [1:0] htrans,       // AHB transfer type
    input wire logic hwrite,             // AHB write
    input wire logic [2:0] hsize,        // AHB size, word only
    input wire logic [31:0] hwdata,      // AHB write data
    input wire logic hready,             // AHB bus ready
    output logic hreadyout,              // AHB slave ready
    output logic [31:0] hrdata,          // AHB read data
    output logic hresp                   // AHB response, always OKAY
);
    import rmp_pkg::*;

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    logic addr_ok;
    logic wr_pend;
    logic [7:0] wr_ofs;
    logic speed_100;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic overrun;
    logic rx_got;
    logic rx_rd;
    logic tx_start;
    rmp_tx_state_e tx_state;

    assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
    assign rx_rd = addr_ok && !hwrite && haddr[7:0] == OFS_RXDATA;
    assign tx_start = wr_pend && wr_ofs == OFS_TXDATA && tx_state == RMP_TX_IDLE;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            wr_pend <= 1'b0;
            wr_ofs <= 8'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend <= addr_ok && hwrite;
            wr_ofs <= haddr[7:0];
            if (addr_ok && !hwrite) begin
                case (haddr[7:0])
                    OFS_CTRL: hrdata <= {31'h0, speed_100};
                    OFS_RXDATA: hrdata <= {23'h0, rx_valid, rx_byte};
                    OFS_STATUS: hrdata <= {29'h0, overrun, link.crs_dv, tx_state == RMP_TX_SEND};
                    default: hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            speed_100 <= CTRL_RESET[CTRL_SPEED100_BIT];
        end else if (wr_pend && wr_ofs == OFS_CTRL) begin
            speed_100 <= hwdata[CTRL_SPEED100_BIT];
        end
    end

    // ------------------------------------------------------------
    // Transmit: byte to four di-bits
    // ------------------------------------------------------------
    logic [7:0] tx_sh;
    logic [1:0] tx_idx;
    logic [3:0] tx_cnt;
    logic [3:0] per_last;

    assign per_last = speed_100 ? 4'(DIBIT_CYC_100 - 1) : 4'(DIBIT_CYC_10 - 1);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tx_state <= RMP_TX_IDLE;
            tx_sh <= 8'h00;
            tx_idx <= 2'h0;
            tx_cnt <= 4'h0;
            link.tx_en <= 1'b0;
            link.txd <= 2'b00;
        end else begin
            case (tx_state)
                RMP_TX_IDLE: begin
                    link.tx_en <= 1'b0;
                    link.txd <= 2'b00;
                    if (tx_start) begin
                        tx_sh <= hwdata[7:0];
                        tx_idx <= 2'h0;
                        tx_cnt <= 4'h0;
                        link.tx_en <= 1'b1;
                        link.txd <= hwdata[1:0];
                        tx_state <= RMP_TX_SEND;
                    end
                end
                RMP_TX_SEND: begin
                    if (tx_cnt != per_last) begin
                        tx_cnt <= tx_cnt + 4'h1;
                    end else if (tx_idx == 2'h3) begin
                        link.tx_en <= 1'b0;
                        link.txd <= 2'b00;
                        tx_state <= RMP_TX_IDLE;
                    end else begin
                        tx_cnt <= 4'h0;
                        tx_idx <= tx_idx + 2'h1;
                        link.txd <= tx_sh[2 * (tx_idx + 2'h1) +: 2];
                    end
                end
                default: tx_state <= RMP_TX_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Receive: di-bits to bytes
    // ------------------------------------------------------------
    logic in_frame;
    logic [3:0] rx_cnt;
    logic [1:0] rx_idx;
    logic [7:0] rx_sh;
    logic rx_sample;

    assign rx_sample = in_frame && rx_cnt == (per_last >> 1);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            in_frame <= 1'b0;
            rx_cnt <= 4'h0;
            rx_idx <= 2'h0;
            rx_sh <= 8'h00;
            rx_got <= 1'b0;
        end else begin
            rx_got <= 1'b0;
            rx_cnt <= (rx_cnt == per_last || !in_frame) ? 4'h0 : rx_cnt + 4'h1;
            if (!in_frame) begin
                in_frame <= link.crs_dv && link.rxd != 2'b00;
                rx_idx <= 2'h0;
            end else if (rx_sample) begin
                if (!link.crs_dv && rx_idx[0]) begin
                    in_frame <= 1'b0;
                end else begin
                    rx_sh <= {link.rxd, rx_sh[7:2]};
                    rx_idx <= rx_idx + 2'h1;
                    rx_got <= rx_idx == 2'h3;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            overrun <= 1'b0;
        end else begin
            if (rx_got) begin
                rx_byte <= rx_sh;
                rx_valid <= 1'b1;
                overrun <= overrun || (rx_valid && !rx_rd);
            end else if (rx_rd) begin
                rx_valid <= 1'b0;
            end
            if (wr_pend && wr_ofs == OFS_STATUS && hwdata[STAT_OVERRUN_BIT] && !rx_got) begin
                overrun <= 1'b0;
            end
        end
    end
endmodule : rmp_mac

// ### verification/rmp_sva.sv
`timescale 1ns/10ps
module rmp_sva (
    input wire logic ref_clk,   // Reference clock
    input wire logic sys_rst,   // Synchronous reset
    input wire logic [1:0] txd, // Transmit di-bit
    input wire logic tx_en,     // Transmit enable
    input wire logic [1:0] rxd, // Receive di-bit
    input wire logic rx_er,     // Receive error
    input wire logic crs_dv     // Carrier sense, data valid
);
    // ------------------------------------------------------------
    // Link timing at 10 Mb/s
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    a_txd_idle_zero: assert property (!tx_en |-> txd == 2'h0)
        else $error("transmit data not idle");
    a_tx_dibit_hold: assert property (tx_en && $changed(txd) |=> $stable(txd)[*8])
        else $error("transmit di-bit held too short");
    a_tx_byte_len: assert property ($rose(tx_en) |-> tx_en[*8] ##33 !tx_en)
        else $error("transmit byte length wrong");
    a_rxd_dibit_hold: assert property ($changed(rxd) |=> $stable(rxd)[*8])
        else $error("receive di-bit held too short");
    a_rxd_zero_start: assert property ($rose(crs_dv) && !$past(crs_dv, 11)
        |-> (rxd == 2'h0)[*8])
        else $error("receive data not zero at carrier start");
    a_crs_drop_nibble: assert property ($fell(crs_dv) |=> !crs_dv[*8])
        else $error("carrier sense low for less than a di-bit");
    a_crs_toggle_high: assert property ($rose(crs_dv) && $past(crs_dv, 11)
        |=> crs_dv[*8])
        else $error("carrier sense toggle too short");
    a_rxer_one_pulse: assert property (rx_er |=> !rx_er)
        else $error("receive error longer than one cycle");

    c_tx_start: cover property ($rose(tx_en));
    c_crs_toggle: cover property ($rose(crs_dv) && $past(crs_dv, 11));
    c_crs_end: cover property ($fell(crs_dv));
endmodule : rmp_sva

// ### verification/testbench.sv
`timescale 1ns/10ps
module testbench;
    import rmp_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, instances and scenarios
    // ------------------------------------------------------------
    logic mclk = 1'b0, sys_rst = 1'b1, line_rx_in = 1'b0, squelch_in = 1'b0;
    logic clock_mode_strap = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic line_tx_en, ref_clock_output_oe, interrupt_output_n, interrupt_output_n_oe;
    logic hreadyout, hresp;
    logic [1:0] line_txd;
    logic [15:0] status_basic, status_special;
    int fail_count = 0;
    int checked = 0;

    always #10 mclk = ~mclk;

    rmp_rmii_if rmii (.ref_clk(mclk));
    rmp_phy #(.JABBER_CYCLES(30), .LINK_LOSS_CYCLES(300)) u_rmp_phy (.mclk(mclk),
        .sys_rst(sys_rst), .link(rmii), .line_rx_in(line_rx_in), .squelch_in(squelch_in),
        .speed_100(1'b0), .clock_mode_strap(clock_mode_strap), .line_tx_en(line_tx_en),
        .line_txd(line_txd), .status_basic(status_basic), .status_special(status_special),
        .ref_clock_output_oe(ref_clock_output_oe), .interrupt_output_n(interrupt_output_n),
        .interrupt_output_n_oe(interrupt_output_n_oe));
    rmp_mac u_rmp_mac (.mclk(mclk), .sys_rst(sys_rst), .link(rmii), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));
    rmp_sva chk (.ref_clk(mclk), .sys_rst(sys_rst), .txd(rmii.txd), .tx_en(rmii.tx_en),
        .rxd(rmii.rxd), .rx_er(rmii.rx_er), .crs_dv(rmii.crs_dv));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        haddr <= {24'h00, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge mclk);
        while (hreadyout !== 1'b1) @(posedge mclk);
        rd = hrdata;
    endtask : ahb

    task automatic test_reset;
        ahb(1'b0, OFS_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        ahb(1'b1, OFS_CTRL, 32'h1);
        ahb(1'b0, OFS_CTRL, 32'h0);
        check(rd, 32'h1);
        ahb(1'b1, OFS_CTRL, 32'h0);
        check(32'(hresp), 32'h0);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check(rd, 32'h0);
        check(32'(interrupt_output_n_oe), 32'h1);
        check(32'(ref_clock_output_oe), 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_transmit;
        logic [7:0] b;
        b = 8'h9E;
        ahb(1'b1, OFS_TXDATA, {24'h0, b});
        for (int i = 0; i < 50 && rmii.tx_en !== 1'b1; i++) @(negedge mclk);
        for (int k = 0; k < 4; k++) begin
            check(32'(rmii.txd), 32'(b[2*k +: 2]));
            @(negedge mclk);
            if (k < 3) check(32'(line_txd), 32'(b[2*k +: 2]));
            repeat (9) @(negedge mclk);
        end
        check(32'(rmii.tx_en), 32'h0);
        check(32'(line_tx_en), 32'h0);
        check(32'(status_basic[JABBER_BIT]), 32'h1);
        check(32'(interrupt_output_n), 32'h0);
        repeat (5) @(negedge mclk);
        check(32'(status_basic[JABBER_BIT]), 32'h0);
        check(32'(line_txd), 32'h0);
        $display("test_transmit done");
    endtask : test_transmit

    task automatic test_receive;
        logic [7:0] b;
        b = 8'hA5;
        @(posedge mclk);
        squelch_in <= 1'b1;
        repeat (8) @(posedge mclk);
        ahb(1'b0, OFS_STATUS, 32'h0);
        check(32'(rd[STAT_CRS_BIT]), 32'h1);
        for (int i = 0; i < 8; i++) begin
            line_rx_in <= ~b[i];
            repeat (2) @(posedge mclk);
            line_rx_in <= b[i];
            repeat (3) @(posedge mclk);
        end
        line_rx_in <= 1'b0;
        squelch_in <= 1'b0;
        for (int i = 0; i < 200; i++) begin
            ahb(1'b0, OFS_RXDATA, 32'h0);
            if (rd[RXDATA_VALID_BIT] === 1'b1) break;
        end
        check(rd, 32'h0000_01A5);
        $display("test_receive done");
    endtask : test_receive

    task automatic test_line;
        line_rx_in <= 1'b1;
        repeat (2) @(posedge mclk);
        line_rx_in <= 1'b0;
        repeat (8) @(posedge mclk);
        check(32'(status_basic[LINK_BIT]), 32'h1);
        repeat (330) @(posedge mclk);
        check(32'(status_basic[LINK_BIT]), 32'h0);
        line_rx_in <= 1'b1;
        repeat (30) @(posedge mclk);
        check(32'(status_special[POL_BIT]), 32'h1);
        line_rx_in <= 1'b0;
        repeat (30) @(posedge mclk);
        check(32'(status_special[POL_BIT]), 32'h0);
        $display("test_line done");
    endtask : test_line

    task automatic test_strap;
        clock_mode_strap <= 1'b1;
        sys_rst <= 1'b1;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge mclk);
        check(32'(ref_clock_output_oe), 32'h1);
        check(32'(interrupt_output_n_oe), 32'h0);
        check(32'(interrupt_output_n), 32'h1);
        $display("test_strap done");
    endtask : test_strap

    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_of_test

    initial begin
        repeat (10000) @(posedge mclk);
        fail_count++;
        end_of_test();
    end

    initial begin
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        repeat (12) @(posedge mclk);
        test_reset();
        test_transmit();
        test_receive();
        test_line();
        test_strap();
        end_of_test();
    end
endmodule : testbench
